// file: hw/bds_setpoint_regs.sv
// Setpoint register bank behind an already decoded byte stream from the serial slave engine.
// Assumes the engine delivers start, stop, and each received byte as one-cycle pulses on mclk_i.
`timescale 1ns/1ps
`include "bds_regs.svh"
module bds_setpoint_regs (
  // Clock, reset, enable
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Byte stream from the slave engine
  input wire logic start_i,
  input wire logic stop_i,
  input wire logic rx_valid_i,
  input wire bds_pkg::bds_byte_t rx_data_i,
  input wire logic addr_match_i,
  input wire logic rd_req_i,
  // Read data back to the engine
  output bds_pkg::bds_byte_t tx_data_o,
  output logic tx_valid_o,
  // Setpoint codes for the regulators
  output bds_pkg::bds_byte_t pos_out_code_o,
  output logic [`BDS_POS_GATE_W-1:0] pos_gate_code_o,
  output logic [`BDS_NEG_GATE_W-1:0] neg_gate_code_o,
  output logic [`BDS_LED_SCALE_W-1:0] led_scale_frac_o
);
  import bds_pkg::*;

  bds_state_t state;
  bds_byte_t ptr;
  bds_byte_t pos_out;
  logic [`BDS_POS_GATE_W-1:0] pos_gate;
  logic [`BDS_NEG_GATE_W-1:0] neg_gate;
  logic [`BDS_LED_SCALE_W-1:0] led_scale;
  bds_byte_t pos_clamped;
  logic wr_en;

  function automatic bds_byte_t read_mux(input bds_byte_t a);
    case (a)
      `BDS_OFS_POS_OUT: read_mux = pos_out;
      `BDS_OFS_POS_GATE: read_mux = {2'h0, pos_gate};
      `BDS_OFS_NEG_GATE: read_mux = {3'h0, neg_gate};
      `BDS_OFS_LED_SCALE: read_mux = {1'h0, led_scale};
      default: read_mux = 8'h00;
    endcase
  endfunction

  // Framing: address byte, pointer byte, then data bytes until stop
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state <= BDS_ST_IDLE;
    end else if (ce_i) begin
      if (stop_i) begin
        state <= BDS_ST_IDLE;
      end else if (start_i) begin
        state <= addr_match_i ? (rd_req_i ? BDS_ST_READ : BDS_ST_PTR) : BDS_ST_IDLE;
      end else if (rx_valid_i) begin
        case (state)
          BDS_ST_PTR: state <= BDS_ST_DATA;
          BDS_ST_DATA: state <= BDS_ST_DATA;
          BDS_ST_READ: state <= BDS_ST_READ;
          BDS_ST_IDLE: state <= BDS_ST_IDLE;
          default: state <= BDS_ST_IDLE;
        endcase
      end
    end
  end

  // Pointer auto-increments so bursts walk the bank
  // Reads step on the request itself, so back-to-back requests never lose a step
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      ptr <= 8'h00;
    end else if (ce_i && rx_valid_i && !start_i && !stop_i) begin
      if (state == BDS_ST_PTR) begin
        ptr <= rx_data_i;
      end else if ((state == BDS_ST_DATA) || (state == BDS_ST_READ)) begin
        ptr <= ptr + 8'h01;
      end
    end
  end

  assign wr_en = ce_i && rx_valid_i && !start_i && !stop_i && (state == BDS_ST_DATA);

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pos_out <= `BDS_RST_POS_OUT;
      pos_gate <= `BDS_RST_POS_GATE;
      neg_gate <= `BDS_RST_NEG_GATE;
      led_scale <= `BDS_RST_LED_SCALE;
    end else if (wr_en) begin
      case (ptr)
        `BDS_OFS_POS_OUT: pos_out <= rx_data_i;
        `BDS_OFS_POS_GATE: pos_gate <= rx_data_i[`BDS_POS_GATE_W-1:0];
        `BDS_OFS_NEG_GATE: neg_gate <= rx_data_i[`BDS_NEG_GATE_W-1:0];
        `BDS_OFS_LED_SCALE: led_scale <= rx_data_i[`BDS_LED_SCALE_W-1:0];
        default: pos_out <= pos_out;
      endcase
    end
  end

  // One read byte per engine request while in a read frame
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      tx_data_o <= 8'h00;
      tx_valid_o <= 1'b0;
    end else if (ce_i) begin
      tx_valid_o <= (state == BDS_ST_READ) && rx_valid_i && !start_i && !stop_i;
      if ((state == BDS_ST_READ) && rx_valid_i && !start_i && !stop_i) begin
        tx_data_o <= read_mux(ptr);
      end
    end
  end

  bds_sat u_sat (
    .code_i(pos_out),
    .code_o(pos_clamped)
  );

  // Codes registered toward the analogue side; gate codes above 0x28 are unused, passed raw
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pos_out_code_o <= `BDS_RST_POS_OUT;
      pos_gate_code_o <= `BDS_RST_POS_GATE;
      neg_gate_code_o <= `BDS_RST_NEG_GATE;
      led_scale_frac_o <= `BDS_RST_LED_SCALE;
    end else if (ce_i) begin
      pos_out_code_o <= pos_clamped;
      pos_gate_code_o <= pos_gate;
      neg_gate_code_o <= neg_gate;
      // Scale code only; the sink multiplies it into the resistor-set full scale
      led_scale_frac_o <= led_scale;
    end
  end

  a_pos_sat: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && pos_out > 8'h8C |=> pos_out_code_o == 8'h8C)
    else $error("positive output code not saturated");
  a_pos_pass: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && pos_out >= 8'h0A && pos_out <= 8'h8C |=> pos_out_code_o == $past(pos_out))
    else $error("positive output code altered in range");
  a_gate_write: assert property (@(posedge mclk_i) disable iff (rst_i)
    wr_en && ptr == 8'h04 |=> pos_gate == $past(rx_data_i[5:0]))
    else $error("positive gate write lost");
  a_neg_write: assert property (@(posedge mclk_i) disable iff (rst_i)
    wr_en && ptr == 8'h05 |=> neg_gate == $past(rx_data_i[4:0]))
    else $error("negative gate write lost");
  a_led_write: assert property (@(posedge mclk_i) disable iff (rst_i)
    wr_en && ptr == 8'h06 |=> ##1 led_scale_frac_o == $past(rx_data_i[6:0], 2) || !$past(ce_i))
    else $error("LED scale not forwarded");
  a_led_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
    !wr_en |=> $stable(led_scale))
    else $error("LED scale changed without write");
  a_frame_idle: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && stop_i |=> state == BDS_ST_IDLE && !wr_en)
    else $error("stop did not end frame");
  a_upper_zero: assert property (@(posedge mclk_i) disable iff (rst_i)
    tx_valid_o && $past(ptr) == 8'h06 |-> tx_data_o[7] == 1'b0)
    else $error("unused bit read as one");
  a_read_step: assert property (@(posedge mclk_i) disable iff (rst_i)
    ce_i && rx_valid_i && !start_i && !stop_i && state == BDS_ST_READ
    |=> ptr == $past(ptr) + 8'h01)
    else $error("read pointer did not step");
  c_write_led: cover property (@(posedge mclk_i) wr_en && ptr == 8'h06);
  c_ce_freeze: cover property (@(posedge mclk_i) !ce_i && start_i);
  c_write_burst: cover property (@(posedge mclk_i) wr_en ##1 wr_en);
  c_read_byte: cover property (@(posedge mclk_i) tx_valid_o);
endmodule

// file: hw/bds_regs.svh
// Register offsets, field layouts, reset values and decode constants of the setpoint bank.
// Assumes inclusion by bare name from the design modules.
// Contract
// - Positive output code resets to 6 V; 0x0A is 5 V, 0.1 V steps, saturating 18 V at 0x8C.
// - Positive gate field bits 5:0, reset zero, 8 V plus 0.5 V steps to 28 V.
// - Negative gate field bits 4:0, reset zero, -6 V minus 0.5 V steps to -21.5 V.
// - LED scale field bits 6:0, resets to top code, 36.5 percent plus 0.5 percent steps.
// - LED scale is a fraction of the resistor-set full-scale current, never absolute.
`ifndef BDS_REGS_SVH
`define BDS_REGS_SVH
`define BDS_OFS_POS_OUT 8'h03
`define BDS_OFS_POS_GATE 8'h04
`define BDS_OFS_NEG_GATE 8'h05
`define BDS_OFS_LED_SCALE 8'h06
`define BDS_RST_POS_OUT 8'h14
`define BDS_RST_POS_GATE 6'h00
`define BDS_RST_NEG_GATE 5'h00
`define BDS_RST_LED_SCALE 7'h7F
`define BDS_POS_OUT_MIN 8'h0A
`define BDS_POS_OUT_MAX 8'h8C
`define BDS_POS_GATE_MAX 6'h28
`define BDS_POS_GATE_W 6
`define BDS_NEG_GATE_W 5
`define BDS_LED_SCALE_W 7
`endif

// file: hw/bds_pkg.sv
// Types shared by the setpoint bank modules.
// Assumes the constants header sits beside it.
package bds_pkg;
  typedef logic [7:0] bds_byte_t;
  typedef enum logic [3:0] {
    BDS_ST_IDLE = 4'h1,
    BDS_ST_PTR = 4'h2,
    BDS_ST_DATA = 4'h4,
    BDS_ST_READ = 4'h8
  } bds_state_t;
endpackage

// file: hw/bds_sat.sv
// Saturating clamp of the positive output code onto the regulator range.
// Assumes a combinational caller.
`timescale 1ns/1ps
`include "bds_regs.svh"
module bds_sat (
  // Raw and clamped code
  input wire bds_pkg::bds_byte_t code_i,
  output bds_pkg::bds_byte_t code_o
);
  import bds_pkg::*;
  // Codes above the top step still mean 18 V; below 0x0A is undefined, held at 5 V
  assign code_o = (code_i > `BDS_POS_OUT_MAX) ? `BDS_POS_OUT_MAX :
                  (code_i < `BDS_POS_OUT_MIN) ? `BDS_POS_OUT_MIN : code_i;
endmodule

// file: testbench/bds_host_model.sv
// Bus master model: drives the byte stream that the serial slave engine decodes.
// Assumes the bench calls its tasks one at a time, never two in one cycle.
`timescale 1ns/1ps
module bds_host_model (
  // Clock and read answer
  input wire logic mclk_i,
  input wire logic tx_valid_i,
  input wire bds_pkg::bds_byte_t tx_data_i,
  // Byte stream
  output logic start_o,
  output logic stop_o,
  output logic valid_o,
  output logic match_o,
  output logic rd_o,
  output bds_pkg::bds_byte_t data_o
);
  initial begin
    {start_o, stop_o, valid_o, match_o, rd_o} = '0;
    data_o = 8'hA5;
  end
  // Start or repeated start carrying the address verdict and direction
  task automatic frame(input logic rd, input logic match);
    @(posedge mclk_i); #1;
    start_o = 1'b1; rd_o = rd; match_o = match;
    @(posedge mclk_i); #1;
    // Released lines show the inverse so stale values never pass
    start_o = 1'b0; rd_o = ~rd; match_o = ~match;
  endtask
  // Register address byte first, then data bytes
  task automatic put(input bds_pkg::bds_byte_t b);
    @(posedge mclk_i); #1;
    valid_o = 1'b1; data_o = b;
    @(posedge mclk_i); #1;
    valid_o = 1'b0; data_o = ~b;
  endtask
  task automatic get(output bds_pkg::bds_byte_t b, output logic ok);
    put(data_o);
    ok = tx_valid_i; b = tx_data_i;
  endtask
  task automatic stop();
    @(posedge mclk_i); #1;
    stop_o = 1'b1;
    @(posedge mclk_i); #1;
    stop_o = 1'b0;
  endtask
endmodule

// file: testbench/bds_setpoint_regs_test.sv
// Self-checking bench for the setpoint bank: random and corner bursts, readback.
// Assumes the host model and the design files are compiled first.
`timescale 1ns/1ps
module bds_setpoint_regs_test;
  import bds_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic start_i, stop_i, rx_valid_i, addr_match_i, rd_req_i, tx_valid_o, ok;
  bds_byte_t rx_data_i, tx_data_o, pos_o, b;
  logic [5:0] pg_o;
  logic [4:0] ng_o;
  logic [6:0] led_o;
  logic [31:0] seed = 32'h00008F88; // 36744
  logic [31:0] v;
  logic [31:0] corner [4] = '{32'h00000000, 32'hFFFFFFFF, 32'h7F1F288C, 32'h8020C00A};
  int error_cnt = 0;
  int checked = 0;
  always #12.5 mclk_i = ~mclk_i;
  bds_setpoint_regs dut_u (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce_i),
    .start_i(start_i), .stop_i(stop_i), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
    .addr_match_i(addr_match_i), .rd_req_i(rd_req_i), .tx_data_o(tx_data_o),
    .tx_valid_o(tx_valid_o), .pos_out_code_o(pos_o), .pos_gate_code_o(pg_o),
    .neg_gate_code_o(ng_o), .led_scale_frac_o(led_o));
  bds_host_model host_u (.mclk_i(mclk_i), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
    .start_o(start_i), .stop_o(stop_i), .valid_o(rx_valid_i), .match_o(addr_match_i),
    .rd_o(rd_req_i), .data_o(rx_data_i));
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic bds_byte_t clamp(input bds_byte_t c);
    return (c < 8'h0A) ? 8'h0A : (c > 8'h8C) ? 8'h8C : c;
  endfunction
  task automatic cmp(input string what, input bds_byte_t exp, input bds_byte_t got);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic codes(input logic [31:0] e);
    cmp("pos_out", clamp(e[7:0]), pos_o);
    cmp("pos_gate", {2'h0, e[13:8]}, {2'h0, pg_o});
    cmp("neg_gate", {3'h0, e[20:16]}, {3'h0, ng_o});
    cmp("led_scale", {1'h0, e[30:24]}, {1'h0, led_o});
  endtask
  task automatic finish_test();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #(25 * 10000);
    error_cnt++;
    finish_test();
  end
  initial begin
    repeat (20) @(posedge mclk_i);
    #1 rst_i = 1'b0;
    @(posedge mclk_i); #1;
    codes(32'h7F000014);
    $display("test reset_values done");
    for (int i = 0; i < 24; i++) begin
      v = (i < 4) ? corner[i] : xs();
      host_u.frame(1'b0, 1'b1);
      host_u.put(8'h03);
      for (int k = 0; k < 4; k++) host_u.put(v[8*k +: 8]);
      host_u.stop();
      repeat (3) @(posedge mclk_i);
      #1 codes(v);
      // Pointer reloaded, then a repeated start turns the frame round
      host_u.frame(1'b0, 1'b1);
      host_u.put(8'h03);
      host_u.frame(1'b1, 1'b1);
      for (int k = 0; k < 4; k++) begin
        host_u.get(b, ok);
        cmp("tx_valid", 8'h01, {7'h0, ok});
        cmp("readback", v[8*k +: 8] & ((k == 0) ? 8'hFF : (k == 3) ? 8'h7F : (k == 1) ? 8'h3F : 8'h1F), b);
      end
      host_u.stop();
    end
    $display("test burst_readback done");
    host_u.frame(1'b0, 1'b0);
    host_u.put(8'h03);
    host_u.put(8'h55);
    host_u.stop();
    repeat (3) @(posedge mclk_i);
    #1 codes(v);
    $display("test foreign_address done");
    // Enable low: a whole matched write frame must leave every code untouched
    ce_i = 1'b0;
    host_u.frame(1'b0, 1'b1);
    host_u.put(8'h03);
    host_u.put(8'h55);
    host_u.stop();
    ce_i = 1'b1;
    repeat (3) @(posedge mclk_i);
    #1 codes(v);
    $display("test enable_freeze done");
    finish_test();
  end
endmodule
